/* hw/wdg_counter.sv */
// wdg_counter: watchdog period counter on oscillator ticks.
// assumes tick is a synchronised one-cycle pulse per oscillator period.
`timescale 1ns/100ps
module wdg_counter #(
   parameter int unsigned BASE = wdg_pkg::BASE_PERIOD
) (
   input  wire logic                       ref_clk,
   input  wire logic                       rst,
   input  wire logic                       run,
   input  wire logic                       restart,
   input  wire logic                       tick,
   input  wire logic [wdg_pkg::SEL_W-1:0]  sel,
   output logic                            expire
);
   logic [wdg_pkg::CNT_W-1:0] count;
   // period doubles per select code
   wire  [wdg_pkg::CNT_W-1:0] limit =
      wdg_pkg::CNT_W'(BASE) << sel;
   wire  hit = tick && (count >= limit - 1'b1);
   wire  [wdg_pkg::CNT_W-1:0] next_count =
      (!run || restart || hit) ? '0 : (tick ? count + 1'b1 : count);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         count  <= '0;
         expire <= 1'b0;
      end else begin
         count  <= next_count;
         expire <= run && !restart && hit;
      end
   end
endmodule

/* hw/wdg_guard.sv */
// wdg_guard: watchdog enable and time-out selection guard with control register.
// assumes ctrl writes come from the core on ref_clk; fuses are static levels,
// oscillator tick arrives from another domain as a level toggling per period.
`timescale 1ns/100ps
module wdg_guard #(
   parameter int unsigned BASE = wdg_pkg::BASE_PERIOD
) (
   input  wire logic                       ref_clk,
   input  wire logic                       rst,
   input  wire logic                       legacy_compat_fuse,
   input  wire logic                       always_on_fuse,
   input  wire logic                       wr_en,
   input  wire logic [wdg_pkg::REG_W-1:0]  wr_data,
   input  wire logic                       restart,
   input  wire logic                       osc_toggle,
   output logic [wdg_pkg::REG_W-1:0]       watchdog_control_reg,
   output logic                            watchdog_running,
   output logic [wdg_pkg::SEL_W-1:0]       timeout_select,
   output logic [1:0]                      safety_level,
   output logic                            chip_reset
);
   ////////////////////////////////////////////////////////////////////////////////
   // fuse and oscillator synchronisers
   logic [1:0] compat_sync;
   logic [1:0] aon_sync;
   logic [2:0] osc_sync;
   logic       fuses_valid;
   logic [1:0] strap_cnt;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         compat_sync <= 2'b00;
         aon_sync    <= 2'b00;
         osc_sync    <= 3'b000;
      end else begin
         compat_sync <= {compat_sync[0], legacy_compat_fuse};
         aon_sync    <= {aon_sync[0], always_on_fuse};
         osc_sync    <= {osc_sync[1:0], osc_toggle};
      end
   end

   wire osc_tick = osc_sync[2] ^ osc_sync[1];

   // level decode from fuses
   wdg_pkg::wdg_level_type level;
   wire wdg_pkg::wdg_level_type fuse_level =
      aon_sync[1]    ? wdg_pkg::WDG_LEVEL2 :
      compat_sync[1] ? wdg_pkg::WDG_LEVEL0 : wdg_pkg::WDG_LEVEL1;

   ////////////////////////////////////////////////////////////////////////////////
   // write decode
   wire wr_on     = wr_data[wdg_pkg::ON_BIT];
   wire wr_unlock = wr_data[wdg_pkg::UNLOCK_BIT];
   wire [wdg_pkg::SEL_W-1:0] wr_sel = wr_data[wdg_pkg::SEL_LSB +: wdg_pkg::SEL_W];
   wire is_l0 = (level == wdg_pkg::WDG_LEVEL0);
   wire is_l2 = (level == wdg_pkg::WDG_LEVEL2);

   // arming needs both unlock and on in one write
   wire arm_write  = wr_en && wr_unlock && wr_on;
   wire win_open;
   // the protected write is the first one inside the window with unlock clear
   wire timed_write = wr_en && win_open && !wr_unlock;

   wdg_window #(
      .CYCLES (wdg_pkg::WINDOW_CYC)
   ) u_window (
      .ref_clk (ref_clk),
      .rst     (rst),
      .arm     (arm_write),
      .consume (timed_write),
      .open    (win_open)
   );

   // a window one cycle shorter says whether the main one is still open at the
   // coming edge, so the registered unlock readback clears on time
   wire view_open;

   wdg_window #(
      .CYCLES (wdg_pkg::WINDOW_CYC - 1)
   ) u_view (
      .ref_clk (ref_clk),
      .rst     (rst),
      .arm     (arm_write),
      .consume (timed_write),
      .open    (view_open)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // protected state
   logic                       on_state;
   logic [wdg_pkg::SEL_W-1:0]  sel_state;

   // enabling is never restricted
   // level 0 and 1 disable only in a timed write
   // level 2 cannot be turned off, write value ignored
   wire next_on =
      is_l2                     ? 1'b1 :
      (wr_en && wr_on)          ? 1'b1 :
      (timed_write && !wr_on)   ? 1'b0 :
      on_state;

   // level 0 selection is free, otherwise only in timed write
   // level 2 takes selection only from timed write
   wire sel_take = wr_en && (is_l0 || timed_write);
   wire [wdg_pkg::SEL_W-1:0] next_sel = sel_take ? wr_sel : sel_state;

   // strap only once the synchronisers carry the fuse levels, fuses then stay put
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         level       <= wdg_pkg::WDG_LEVEL1;
         fuses_valid <= 1'b0;
         strap_cnt   <= 2'h0;
      end else if (!fuses_valid) begin
         strap_cnt <= strap_cnt + 2'h1;
         if (strap_cnt == 2'(wdg_pkg::STRAP_CYC)) begin
            level       <= fuse_level;
            fuses_valid <= 1'b1;
         end
      end
   end

   wire level_is_2_now = fuses_valid ? is_l2 : (fuse_level == wdg_pkg::WDG_LEVEL2);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         on_state  <= 1'b0;
         sel_state <= wdg_pkg::SEL_RESET;
      end else if (!fuses_valid) begin
         on_state  <= level_is_2_now;
         sel_state <= wdg_pkg::SEL_RESET;
      end else begin
         on_state  <= next_on;
         sel_state <= next_sel;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // period counter and reset request
   logic expire;

   wdg_counter #(
      .BASE (BASE)
   ) u_counter (
      .ref_clk (ref_clk),
      .rst     (rst),
      .run     (on_state),
      .restart (restart),
      .tick    (osc_tick),
      .sel     (sel_state),
      .expire  (expire)
   );

   // stretch the reset request so the chip reset logic sees it
   logic [2:0] rst_pulse;
   wire  [2:0] next_rst_pulse =
      expire ? 3'(wdg_pkg::RST_PULSE_CYC) :
      (rst_pulse != 3'h0) ? rst_pulse - 3'h1 : 3'h0;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rst_pulse <= 3'h0;
      end else begin
         rst_pulse <= next_rst_pulse;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // registered outputs; reserved bits read zero, unlock reads while window open
   wire next_on_view = fuses_valid ? next_on : level_is_2_now;
   wire [wdg_pkg::SEL_W-1:0] next_sel_view = fuses_valid ? next_sel : wdg_pkg::SEL_RESET;
   wire next_unlock_view = arm_write || (view_open && !timed_write);
   wire [wdg_pkg::REG_W-1:0] next_view =
      {3'h0, next_unlock_view, next_on_view, next_sel_view};

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         watchdog_control_reg <= wdg_pkg::CTRL_RESET;
         watchdog_running     <= 1'b0;
         timeout_select       <= wdg_pkg::SEL_RESET;
         safety_level         <= 2'b00;
         chip_reset           <= 1'b0;
      end else begin
         watchdog_control_reg <= next_view;
         watchdog_running     <= next_on_view;
         timeout_select       <= next_sel_view;
         safety_level         <= fuses_valid ? level : fuse_level;
         chip_reset           <= (next_rst_pulse != 3'h0);
      end
   end
endmodule

/* hw/wdg_pkg.sv */
// wdg_pkg: constants and types for the watchdog configuration guard.
// assumes a single system clock; the watchdog oscillator tick arrives as a pin.
package wdg_pkg;
   localparam int unsigned SEL_LSB      = 0;
   localparam int unsigned SEL_W        = 3;
   localparam int unsigned ON_BIT       = 3;
   localparam int unsigned UNLOCK_BIT   = 4;
   localparam int unsigned REG_W        = 8;
   localparam logic [7:0]  CTRL_RESET   = 8'h00;
   localparam logic [2:0]  SEL_RESET    = 3'h0;
   localparam int unsigned WINDOW_CYC   = 4;
   localparam int unsigned WIN_CNT_W    = 3;
   localparam int unsigned BASE_PERIOD  = 16384;
   localparam int unsigned CNT_W        = 22;
   localparam int unsigned RST_PULSE_CYC = 4;
   localparam int unsigned STRAP_CYC    = 2;

   typedef enum logic [1:0] {
      WDG_LEVEL0 = 2'b00,
      WDG_LEVEL1 = 2'b01,
      WDG_LEVEL2 = 2'b11
   } wdg_level_type;
endpackage

/* hw/wdg_window.sv */
// wdg_window: change window timer opened by an arming write.
// assumes arm is a one-cycle pulse on ref_clk.
`timescale 1ns/100ps
module wdg_window #(
   parameter int unsigned CYCLES = wdg_pkg::WINDOW_CYC
) (
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic arm,
   input  wire logic consume,
   output logic      open
);
   logic [wdg_pkg::WIN_CNT_W-1:0] count;
   wire  [wdg_pkg::WIN_CNT_W-1:0] full_count = wdg_pkg::WIN_CNT_W'(CYCLES);
   wire  [wdg_pkg::WIN_CNT_W-1:0] next_count =
      arm ? full_count :
      (consume || count == '0) ? '0 : count - 1'b1;

   assign open = (count != '0);

   // window closes itself after the fixed count
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end
endmodule

/* tb/wdg_guard_checker.sv */
// wdg_guard_checker: port-level checks on the watchdog guard.
// assumes writes start only after the fuses are strapped.
`timescale 1ns/100ps
module wdg_guard_checker (
   input wire logic       ref_clk,
   input wire logic       rst,
   input wire logic       wr_en,
   input wire logic [7:0] wr_data,
   input wire logic [7:0] watchdog_control_reg,
   input wire logic       watchdog_running,
   input wire logic [2:0] timeout_select,
   input wire logic [1:0] safety_level,
   input wire logic       chip_reset
);
   wire       op = watchdog_control_reg[4];
   wire       on = watchdog_running;
   wire       wo = wr_data[3];
   wire [2:0] ws = wr_data[2:0];
   wire [2:0] ts = timeout_select;
   wire       l2 = safety_level == 2'b11;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence s_arm; wr_en && wr_data[4] && wo; endsequence
   sequence s_take; wr_en && op && !wr_data[4]; endsequence
   property p_close; s_arm ##1 !wr_en [*4] |-> op ##1 !op; endproperty
   a_close: assert property (p_close) else $error("window length");
   property p_take; !l2 ##0 s_take |=> on == $past(wo) && ts == $past(ws); endproperty
   a_take: assert property (p_take) else $error("window write lost");
   property p_take2; l2 ##0 s_take |=> on && ts == $past(ws); endproperty
   a_take2: assert property (p_take2) else $error("level 2 write lost");
   property p_keep; safety_level == 2'b01 && wr_en && !op && !wr_data[4]
      |=> $stable(ts) && on >= $past(on); endproperty
   a_keep: assert property (p_keep) else $error("guarded field changed");
   property p_free; safety_level == 2'b00 && wr_en |=> ts == $past(ws); endproperty
   a_free: assert property (p_free) else $error("selection not taken");
   property p_on; !l2 && wr_en && wo |=> on; endproperty
   a_on: assert property (p_on) else $error("enable ignored");
   property p_lock; $past(l2) |-> on && watchdog_control_reg[3]; endproperty
   a_lock: assert property (p_lock) else $error("level 2 not running");
   property p_pulse; $rose(chip_reset) |-> chip_reset [*4] ##1 !chip_reset; endproperty
   a_pulse: assert property (p_pulse) else $error("reset pulse length");
endmodule
bind wdg_guard wdg_guard_checker i_chk (.ref_clk(ref_clk), .rst(rst), .wr_en(wr_en),
   .wr_data(wr_data), .watchdog_control_reg(watchdog_control_reg),
   .watchdog_running(watchdog_running), .timeout_select(timeout_select),
   .safety_level(safety_level), .chip_reset(chip_reset));

/* tb/wdg_guard_tb_top.sv */
// wdg_guard_tb_top: random and corner-case bench for the watchdog guard.
// assumes base period 4; a model mirrors every write, checked each cycle after strapping and up to the period tests.
`timescale 1ns/100ps
module wdg_guard_tb_top;
   logic       ref_clk = 0, rst = 1, lc = 0, ao = 0, wr_en = 0, restart = 0;
   logic       osc_toggle = 0, osc_run = 0, cmp = 0, run, crst, m_on;
   logic [7:0] wr_data = 8'h00, rd;
   logic [2:0] sel, m_sel;
   logic [1:0] lvl;
   int         seed = 7, errors = 0, n_compared = 0, win = 0, n, k;
   wire        arm = wr_en & wr_data[4] & wr_data[3];
   wire        take = wr_en & (win > 0) & ~wr_data[4];
   always #2 ref_clk = ~ref_clk;
   always @(posedge ref_clk) osc_toggle <= osc_toggle ^ osc_run;
   wdg_guard #(.BASE(4)) i_dut (.ref_clk(ref_clk), .rst(rst), .legacy_compat_fuse(lc),
      .always_on_fuse(ao), .wr_en(wr_en), .wr_data(wr_data), .restart(restart),
      .osc_toggle(osc_toggle), .watchdog_control_reg(rd), .watchdog_running(run),
      .timeout_select(sel), .safety_level(lvl), .chip_reset(crst));
   ////////////////////////////////////////
   function automatic logic [1:0] lvl_of(input logic c, input logic a);
      return {a, a | ~c};
   endfunction
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_of_test;
      if (errors == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic put(input logic en, input logic [7:0] d);
      @(posedge ref_clk);
      wr_en <= en;
      wr_data <= d;
      restart <= ~osc_run & 1'($random(seed));
   endtask
   // win counts the edges left in which a window write is still taken
   always @(posedge ref_clk) begin
      if (!rst && wr_en && (lc & ~ao | take)) m_sel = wr_data[2:0];
      m_on = rst ? ao : take ? ao | wr_data[3] : m_on | wr_data[3] & wr_en;
      win = rst || take ? 0 : arm ? 4 : win > 0 ? win - 1 : 0;
      if (rst) m_sel = 3'h0;
   end
   always @(negedge ref_clk) if (cmp) begin
      chk("control", rd, {3'h0, win > 0, m_on, m_sel});
      chk("running", run, m_on);
      chk("select", sel, m_sel);
   end
   initial begin
      for (int fz = 0; fz < 4; fz++) begin
         @(posedge ref_clk);
         {ao, lc} <= 2'(fz);
         rst <= 1'b1;
         cmp = 0;
         osc_run = 0;
         repeat (4) put(0, 8'h00);
         rst <= 1'b0;
         repeat (5) put(0, 8'h00);
         #1 chk("level", lvl, lvl_of(lc, ao));
         cmp = 1;
         for (int g = 0; g < 5; g++) begin
            put(1, 8'h08 | 8'(g));
            put(1, 8'h18);
            repeat (g) put(0, 8'h00);
            put(1, 8'(7 - g));
            put(0, 8'h00);
         end
         repeat (300) begin
            n = $random(seed);
            put(n[8], {3'(n >> 9), n[4], n[3] | n[4], n[2:0]});
         end
         // select codes whose period outlasts the reset pulse
         for (int s = 1; s < 4; s += 2) begin
            put(1, 8'h18);
            put(1, 8'h08 | 8'(s));
            @(posedge ref_clk) {wr_en, restart} <= 2'b01;
            cmp = 0;
            osc_run = 1;
            n = 0;
            k = 0;
            while (crst !== 1'b1 && n < 200) begin
               put(0, 8'h00);
               n++;
            end
            // stop ticks at once so no second expiry lands in the pulse
            osc_run = 0;
            while (crst === 1'b1 && k < 20) begin
               put(0, 8'h00);
               k++;
            end
            if (n >= 200) begin
               errors++;
               end_of_test();
            end
            chk("period", n >= (4 << s) - 1 && n <= (4 << s) + 6, 1);
            chk("pulse", k, wdg_pkg::RST_PULSE_CYC);
         end
      end
      end_of_test();
   end
endmodule
